/* File: rtl/poe_port_params.svh */
// Offsets, field positions, reset values and timing figures for the
// four-port power-sourcing port controller.
// Assumes a 250 MHz core clock and an 8-bit internal register port.
`ifndef POE_PORT_PARAMS_SVH
`define POE_PORT_PARAMS_SVH

`define OFS_DET_EV      8'h04
`define OFS_DET_EV_COR  8'h05
`define OFS_FLT_EV      8'h06
`define OFS_FLT_EV_COR  8'h07
`define OFS_PORT_ST0    8'h0c
`define OFS_PWR_ST      8'h10
`define OFS_OP_MODE     8'h12
`define OFS_DISC_EN     8'h13
`define OFS_DETCLS_EN   8'h14
`define OFS_TIMING      8'h16
`define OFS_PWR_PB      8'h19

`define TIMING_RST      8'h00
`define TDIS_SEL_LSB    0
`define PST_CLASS_LSB   4

`define CLK_HZ          250000000
`define SINE_HZ         110
`define SINE_STEPS      16
`define DC_KEEP_PCT     17
`define CLASS_MV        17500
`define INIT_WAIT       2'h3

`endif

/* File: rtl/poe_port_pkg.sv */
// Types shared by the port controller and its bench.
// Assumes the constants header is included by the modules that use it.
package poe_port_pkg;

    typedef enum logic [1:0] {
        MODE_OFF    = 2'h0,
        MODE_MANUAL = 2'h1,
        MODE_SEMI   = 2'h2,
        MODE_AUTO   = 2'h3
    } op_mode_t;

    typedef enum logic [3:0] {
        PS_IDLE     = 4'h1,
        PS_DETECT   = 4'h2,
        PS_CLASSIFY = 4'h4,
        PS_POWERED  = 4'h8
    } port_st_t;

    // Analog front end results for one port; done flags stay high
    // until the matching run request drops.
    typedef struct packed {
        logic det_done;
        logic det_valid;
        logic class_done;
        logic [2:0] class_lvl;
        logic short_det;
        logic under_cur;
        logic high_imp;
    } afe_t;

endpackage

/* File: rtl/poe_port_ctrl.sv */
// Per-port mode, classification and disconnect control, four ports.
// Assumes an analog front end that runs detection and the class
// regulation loop on request, and a serial slave that turns host
// transfers into one-cycle reg_wr / reg_rd strobes on this clock.
//
// Behaviour
// - Classification regulates port at 17.5 V, reads class.
// - Short during class forces limited gate drive.
// - Class results shown in event and status registers.
// - Each port runs in one of four modes.
// - Auto detects until valid, classifies, powers on.
// - Strap pin picks auto or software control.
// - Semi mode detects and classifies, powers only on push-button.
// - Manual mode runs each command once only.
// - Off mode stays unpowered and clears bits.
// - With AC disconnect off, DC disconnect counts while current below threshold.
// - Timeout switches port off, sets fault bit.
// - Steady current clears the DC disconnect timer.
// - Timeout length comes from timing register field.
// - AC disconnect injects 110 Hz sine wave.
// - High AC impedance runs timer, timeout powers off.
// - Low AC impedance clears the disconnect timer.
`timescale 1ns/10ps
`include "poe_port_params.svh"

module poe_port_ctrl
    import poe_port_pkg::*;
#(
    parameter int unsigned TDIS_BASE_CYC = 75000000,
    parameter int unsigned MPDO_CYC = 100000000,
    parameter int unsigned SINE_STEP_CYC =
        `CLK_HZ / (`SINE_HZ * `SINE_STEPS)
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic self_run,
    input wire afe_t [3:0] afe_in,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [3:0] det_start,
    output logic [3:0] class_run,
    output logic [3:0] class_short_limit,
    output logic [3:0] power_on,
    output logic [3:0] sine_injection_pin,
    output logic [3:0] sine_code
);

    // The keep window is a whole number of cycles, rounded down
    localparam int unsigned KEEP_CYC = MPDO_CYC * `DC_KEEP_PCT / 100;
    localparam logic [15:0][3:0] SINE_LUT = {
        4'h5, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h5, 4'h8,
        4'hb, 4'hd, 4'hf, 4'hf, 4'hf, 4'hd, 4'hb, 4'h8
    };

    typedef struct packed {
        afe_t [3:0] sy1;
        afe_t [3:0] sy2;
        afe_t [3:0] sy3;
        afe_t [3:0] flt;
        logic [2:0] run_sy;
        logic [1:0] init_cnt;
        logic init_done;
        port_st_t [3:0] st;
        op_mode_t [3:0] mode;
        logic [3:0] det_en;
        logic [3:0] cls_en;
        logic [3:0] dc_en;
        logic [3:0] ac_en;
        logic [7:0] timing;
        logic [3:0] det_ev;
        logic [3:0] cls_ev;
        logic [3:0] dis_ev;
        logic [3:0] det_ok;
        logic [3:0][2:0] cls_lvl;
        logic [3:0] det_req;
        logic [3:0] cls_req;
        logic [3:0] cls_short;
        logic [3:0][31:0] dis_cnt;
        logic [3:0][31:0] ok_cnt;
        logic [31:0] sine_div;
        logic [3:0] sine_idx;
        logic [3:0] sine_out;
        logic [3:0] det_run;
        logic [3:0] cls_run;
        logic [3:0] pwr_on;
        logic [3:0] inj_en;
        logic [7:0] rdata;
    } core_t;

    core_t q_ff;
    core_t nxt_q;
    logic [31:0] dis_lim;

    assign dis_lim = TDIS_BASE_CYC << q_ff.timing[`TDIS_SEL_LSB +: 2];

    always_comb
    begin
        logic [3:0] pb_on;
        logic [3:0] pb_off;
        logic clr_det;
        logic clr_flt;
        nxt_q = q_ff;
        pb_on = 4'h0;
        pb_off = 4'h0;
        clr_det = reg_rd && reg_addr == `OFS_DET_EV_COR;
        clr_flt = reg_rd && reg_addr == `OFS_FLT_EV_COR;

        // Three-stage capture; a level is taken once stages 2 and 3 agree
        nxt_q.sy1 = afe_in;
        nxt_q.sy2 = q_ff.sy1;
        nxt_q.sy3 = q_ff.sy2;
        nxt_q.flt = (q_ff.sy2 & q_ff.sy3) | (q_ff.flt & (q_ff.sy2 | q_ff.sy3));
        nxt_q.run_sy = {q_ff.run_sy[1:0], self_run};

        // Strap is taken only after the capture chain has filled
        if (!q_ff.init_done)
        begin
            if (q_ff.init_cnt != `INIT_WAIT)
                nxt_q.init_cnt = q_ff.init_cnt + 2'h1;
            else if (q_ff.run_sy[1] == q_ff.run_sy[2])
            begin
                nxt_q.init_done = 1'b1;
                for (int i = 0; i < 4; i++)
                begin
                    nxt_q.mode[i] = q_ff.run_sy[2] ? MODE_AUTO : MODE_MANUAL;
                end
                if (q_ff.run_sy[2])
                begin
                    nxt_q.det_en = 4'hf;
                    nxt_q.cls_en = 4'hf;
                    nxt_q.dc_en = 4'hf;
                end
            end
        end

        if (reg_wr)
        begin
            case (reg_addr)
                `OFS_OP_MODE:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        nxt_q.mode[i] = op_mode_t'(reg_wdata[2*i +: 2]);
                    end
                end
                `OFS_DISC_EN:
                begin
                    nxt_q.dc_en = reg_wdata[3:0];
                    nxt_q.ac_en = reg_wdata[7:4];
                end
                `OFS_DETCLS_EN:
                begin
                    nxt_q.det_en = reg_wdata[3:0];
                    nxt_q.cls_en = reg_wdata[7:4];
                    nxt_q.det_req = q_ff.det_req | reg_wdata[3:0];
                    nxt_q.cls_req = q_ff.cls_req | reg_wdata[7:4];
                end
                `OFS_TIMING: nxt_q.timing = reg_wdata;
                `OFS_PWR_PB:
                begin
                    pb_on = reg_wdata[3:0];
                    pb_off = reg_wdata[7:4];
                end
                default: ;
            endcase
        end

        // Clear on read first, so that an event in the same cycle survives
        if (clr_det)
        begin
            nxt_q.det_ev = 4'h0;
            nxt_q.cls_ev = 4'h0;
        end
        if (clr_flt)
            nxt_q.dis_ev = 4'h0;

        for (int i = 0; i < 4; i++)
        begin
            unique case (q_ff.st[i])
                PS_IDLE:
                begin
                    // Wait for stale done flags to drain before a new run
                    if (pb_on[i] && q_ff.mode[i] != MODE_OFF)
                        nxt_q.st[i] = PS_POWERED;
                    else if (q_ff.flt[i].det_done || q_ff.flt[i].class_done)
                        nxt_q.st[i] = PS_IDLE;
                    else if (q_ff.mode[i] == MODE_MANUAL)
                    begin
                        if (q_ff.det_req[i])
                        begin
                            nxt_q.st[i] = PS_DETECT;
                            nxt_q.det_req[i] = 1'b0;
                        end
                        else if (q_ff.cls_req[i])
                        begin
                            nxt_q.st[i] = PS_CLASSIFY;
                            nxt_q.cls_req[i] = 1'b0;
                        end
                    end
                    else if (q_ff.mode[i] != MODE_OFF && q_ff.det_en[i])
                        nxt_q.st[i] = PS_DETECT;
                end
                PS_DETECT:
                begin
                    if (q_ff.flt[i].det_done)
                    begin
                        nxt_q.det_ev[i] = 1'b1;
                        nxt_q.det_ok[i] = q_ff.flt[i].det_valid;
                        nxt_q.st[i] = PS_IDLE;
                        // A failed detect drops a queued class request
                        if (q_ff.mode[i] == MODE_MANUAL)
                            nxt_q.cls_req[i] = 1'b0;
                        if (q_ff.flt[i].det_valid)
                        begin
                            if (q_ff.mode[i] == MODE_MANUAL)
                            begin
                                if (q_ff.cls_req[i])
                                    nxt_q.st[i] = PS_CLASSIFY;
                                nxt_q.cls_req[i] = 1'b0;
                            end
                            else if (q_ff.cls_en[i])
                                nxt_q.st[i] = PS_CLASSIFY;
                            else if (q_ff.mode[i] == MODE_AUTO)
                                nxt_q.st[i] = PS_POWERED;
                        end
                    end
                end
                PS_CLASSIFY:
                begin
                    if (q_ff.flt[i].short_det)
                        nxt_q.cls_short[i] = 1'b1;
                    if (q_ff.flt[i].class_done)
                    begin
                        nxt_q.cls_ev[i] = 1'b1;
                        nxt_q.cls_lvl[i] = q_ff.flt[i].class_lvl;
                        nxt_q.cls_short[i] = 1'b0;
                        // Class result never holds back power-on
                        nxt_q.st[i] = q_ff.mode[i] == MODE_AUTO ?
                            PS_POWERED : PS_IDLE;
                    end
                end
                PS_POWERED:
                begin
                    if (q_ff.ac_en[i])
                    begin
                        if (q_ff.flt[i].high_imp)
                            nxt_q.dis_cnt[i] = q_ff.dis_cnt[i] + 32'h1;
                        else
                            nxt_q.dis_cnt[i] = 32'h0;
                    end
                    else if (q_ff.dc_en[i])
                    begin
                        if (q_ff.flt[i].under_cur)
                        begin
                            nxt_q.dis_cnt[i] = q_ff.dis_cnt[i] + 32'h1;
                            nxt_q.ok_cnt[i] = 32'h0;
                        end
                        else if (q_ff.ok_cnt[i] >= KEEP_CYC - 1)
                            nxt_q.dis_cnt[i] = 32'h0;
                        else
                            nxt_q.ok_cnt[i] = q_ff.ok_cnt[i] + 32'h1;
                    end
                    if ((q_ff.ac_en[i] || q_ff.dc_en[i]) &&
                        q_ff.dis_cnt[i] >= dis_lim)
                    begin
                        nxt_q.st[i] = PS_IDLE;
                        nxt_q.dis_ev[i] = 1'b1;
                    end
                    if (pb_off[i])
                        nxt_q.st[i] = PS_IDLE;
                end
            endcase

            // Requests only queue up for ports under command
            if (q_ff.mode[i] != MODE_MANUAL)
            begin
                nxt_q.det_req[i] = 1'b0;
                nxt_q.cls_req[i] = 1'b0;
            end

            // Powered-off mode wipes this port's status and enables; the
            // strap load lands while modes still read off, so skip it then
            if (q_ff.mode[i] == MODE_OFF && q_ff.init_done)
            begin
                nxt_q.st[i] = PS_IDLE;
                nxt_q.det_en[i] = 1'b0;
                nxt_q.cls_en[i] = 1'b0;
                nxt_q.dc_en[i] = 1'b0;
                nxt_q.ac_en[i] = 1'b0;
                nxt_q.det_req[i] = 1'b0;
                nxt_q.cls_req[i] = 1'b0;
                nxt_q.det_ev[i] = 1'b0;
                nxt_q.cls_ev[i] = 1'b0;
                nxt_q.dis_ev[i] = 1'b0;
                nxt_q.det_ok[i] = 1'b0;
                nxt_q.cls_lvl[i] = 3'h0;
                nxt_q.cls_short[i] = 1'b0;
            end
            if (nxt_q.st[i] != PS_POWERED)
            begin
                nxt_q.dis_cnt[i] = 32'h0;
                nxt_q.ok_cnt[i] = 32'h0;
            end
            nxt_q.det_run[i] = nxt_q.st[i] == PS_DETECT;
            nxt_q.cls_run[i] = nxt_q.st[i] == PS_CLASSIFY;
            nxt_q.pwr_on[i] = nxt_q.st[i] == PS_POWERED;
            nxt_q.inj_en[i] = nxt_q.st[i] == PS_POWERED &&
                nxt_q.ac_en[i];
        end

        // One shared sine source; each port gates it onto its pin
        if (q_ff.sine_div >= SINE_STEP_CYC - 1)
        begin
            nxt_q.sine_div = 32'h0;
            nxt_q.sine_idx = q_ff.sine_idx + 4'h1;
        end
        else
            nxt_q.sine_div = q_ff.sine_div + 32'h1;
        nxt_q.sine_out = SINE_LUT[q_ff.sine_idx];

        nxt_q.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `OFS_DET_EV, `OFS_DET_EV_COR:
                    nxt_q.rdata = {q_ff.cls_ev, q_ff.det_ev};
                `OFS_FLT_EV, `OFS_FLT_EV_COR:
                    nxt_q.rdata = {q_ff.dis_ev, 4'h0};
                `OFS_PWR_ST: nxt_q.rdata = {4'h0, q_ff.pwr_on};
                `OFS_OP_MODE: nxt_q.rdata = q_ff.mode;
                `OFS_DISC_EN: nxt_q.rdata = {q_ff.ac_en, q_ff.dc_en};
                `OFS_DETCLS_EN: nxt_q.rdata = {q_ff.cls_en, q_ff.det_en};
                `OFS_TIMING: nxt_q.rdata = q_ff.timing;
                default:
                begin
                    if (reg_addr[7:2] == 6'(`OFS_PORT_ST0 >> 2))
                        nxt_q.rdata = {1'b0, q_ff.cls_lvl[reg_addr[1:0]],
                            3'h0, q_ff.det_ok[reg_addr[1:0]]};
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            q_ff <= '0;
            q_ff.st <= '{PS_IDLE, PS_IDLE, PS_IDLE, PS_IDLE};
            q_ff.timing <= `TIMING_RST;
        end
        else
            q_ff <= nxt_q;
    end

    assign reg_rdata = q_ff.rdata;
    assign det_start = q_ff.det_run;
    assign class_run = q_ff.cls_run;
    assign class_short_limit = q_ff.cls_short;
    assign power_on = q_ff.pwr_on;
    assign sine_injection_pin = q_ff.inj_en;
    assign sine_code = q_ff.sine_out;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic dc_count0;
    assign dc_count0 = q_ff.st[0] == PS_POWERED && q_ff.dc_en[0] &&
        !q_ff.ac_en[0] && q_ff.flt[0].under_cur &&
        q_ff.dis_cnt[0] < dis_lim && q_ff.mode[0] != MODE_OFF && !reg_wr;

    chk_class_drive: assert property (
        q_ff.st[0] == PS_CLASSIFY && !q_ff.flt[0].class_done &&
        q_ff.mode[0] != MODE_OFF |=> class_run[0] && !power_on[0])
        else $error("class loop not held during classification");
    chk_short_hold: assert property (
        class_short_limit[0] && class_run[0] |=>
        class_short_limit[0] || !class_run[0])
        else $error("short limit dropped inside class event");
    chk_class_report: assert property (
        class_run[0] && q_ff.flt[0].class_done &&
        q_ff.mode[0] != MODE_OFF |=> q_ff.cls_ev[0] && !class_run[0])
        else $error("class result not reported");
    chk_auto_power: assert property (
        q_ff.st[0] == PS_CLASSIFY && q_ff.flt[0].class_done &&
        q_ff.mode[0] == MODE_AUTO |=> power_on[0])
        else $error("auto port not powered after class");
    chk_semi_nopower: assert property (
        q_ff.mode[0] == MODE_SEMI && !power_on[0] &&
        !(reg_wr && reg_addr == `OFS_PWR_PB) |=> !power_on[0])
        else $error("semi port powered itself");
    chk_off_quiet: assert property (
        q_ff.mode[0] == MODE_OFF && q_ff.init_done |=>
        !power_on[0] && !det_start[0] &&
        !class_run[0] && q_ff.det_en[0] == 1'b0 && q_ff.dis_ev[0] == 1'b0)
        else $error("off port not quiet");
    chk_dc_count: assert property (
        dc_count0 |=> q_ff.dis_cnt[0] == $past(q_ff.dis_cnt[0]) + 32'h1)
        else $error("dc disconnect timer did not advance");
    chk_dc_timeout: assert property (
        q_ff.st[0] == PS_POWERED && (q_ff.dc_en[0] || q_ff.ac_en[0]) &&
        q_ff.dis_cnt[0] >= dis_lim && q_ff.mode[0] != MODE_OFF |=>
        !power_on[0] && q_ff.dis_ev[0])
        else $error("timeout did not power off");
    chk_ac_clear: assert property (
        q_ff.st[0] == PS_POWERED && q_ff.ac_en[0] &&
        !q_ff.flt[0].high_imp |=> q_ff.dis_cnt[0] == 32'h0)
        else $error("ac timer not cleared");
    chk_off_clears: assert property (
        !power_on[0] |-> q_ff.dis_cnt[0] == 32'h0)
        else $error("stale disconnect count while off");

    cov_class_done: cover property (class_run[0] ##1 !class_run[0]);
    cov_auto_on: cover property (
        q_ff.mode[0] == MODE_AUTO && $rose(power_on[0]));
    cov_disconnect: cover property ($rose(q_ff.dis_ev[0]));
    cov_short: cover property ($rose(class_short_limit[0]));

endmodule

/* File: sim/pd_model.sv */
// Far-side model: analog front end plus the powered device on each port.
// Assumes the bench sets load behaviour through the pd_* inputs.
`timescale 1ns/10ps

module pd_model
    import poe_port_pkg::*;
#(
    parameter int DLY = 10
)
(
    input wire logic mclk,
    input wire logic [3:0] det_start,
    input wire logic [3:0] class_run,
    input wire logic [3:0] power_on,
    input wire logic [3:0] pd_valid,
    input wire logic [3:0][2:0] pd_cls,
    input wire logic [3:0] pd_short,
    input wire logic [3:0] pd_under,
    input wire logic [3:0] pd_himp,
    output afe_t [3:0] afe
);
    logic [3:0][7:0] dcnt = '0;
    logic [3:0][7:0] ccnt = '0;
    logic tog = 1'b0;

    // Done stays up until the run request drops
    always_ff @(posedge mclk)
    begin
        tog <= ~tog;
        for (int n = 0; n < 4; n++)
        begin
            if (!det_start[n])
                dcnt[n] <= 8'h00;
            else if (dcnt[n] != 8'(DLY))
                dcnt[n] <= dcnt[n] + 8'h01;
            if (!class_run[n])
                ccnt[n] <= 8'h00;
            else if (ccnt[n] != 8'(DLY))
                ccnt[n] <= ccnt[n] + 8'h01;
        end
    end

    // Results outside done are garbage, so they toggle every cycle
    always_comb
    begin
        for (int n = 0; n < 4; n++)
        begin
            afe[n].det_done = dcnt[n] == 8'(DLY);
            afe[n].det_valid = afe[n].det_done ? pd_valid[n] : tog;
            afe[n].class_done = ccnt[n] == 8'(DLY);
            afe[n].class_lvl = afe[n].class_done ? pd_cls[n] : {3{tog}};
            afe[n].short_det = pd_short[n] & class_run[n];
            // No load current flows while the switch is open
            afe[n].under_cur = pd_under[n] | ~power_on[n];
            afe[n].high_imp = pd_himp[n] | ~power_on[n];
        end
    end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the four-port mode and disconnect controller.
// Assumes pd_model stands in for the front end and the attached loads.
`timescale 1ns/10ps
`include "poe_port_params.svh"

module tb;
    import poe_port_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic self_run = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [3:0] det_start, class_run, class_short_limit, power_on;
    logic [3:0] sine_injection_pin, sine_code, s;
    afe_t [3:0] afe_in;
    logic [3:0] pd_valid = 4'hf, pd_short = 4'h8;
    logic [3:0] pd_under = 4'h0, pd_himp = 4'h0;
    logic [3:0][2:0] pd_cls = '0;
    logic [3:0] det_d = 4'h0;
    logic [3:0] cls_d = 4'h0;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    string name_q[$];
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'h0bd71845;
    int det_n = 0;
    int cls_n = 0;
    int cp = 0;

    poe_port_ctrl #(.TDIS_BASE_CYC(20), .MPDO_CYC(100), .SINE_STEP_CYC(4))
    poe_port_ctrl_inst (.mclk(mclk), .resetn(resetn), .self_run(self_run),
        .afe_in(afe_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .det_start(det_start), .class_run(class_run),
        .class_short_limit(class_short_limit), .power_on(power_on),
        .sine_injection_pin(sine_injection_pin), .sine_code(sine_code));

    pd_model pd_model_inst (.mclk(mclk), .det_start(det_start),
        .class_run(class_run), .power_on(power_on), .pd_valid(pd_valid),
        .pd_cls(pd_cls), .pd_short(pd_short), .pd_under(pd_under),
        .pd_himp(pd_himp), .afe(afe_in));

    initial
    begin
        forever #2 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    // Read answer is checked one cycle later by the monitor below
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input string what);
        exp_q.push_back(e);
        name_q.push_back(what);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask

    task automatic wait_pw(input int p, input logic v, output int c);
        c = 0;
        while (power_on[p] !== v && c < 2000)
        begin
            @(negedge mclk);
            c++;
        end
    endtask

    // Under-current or high-impedance burst on port 0, then a clean gap
    task automatic load(input bit ac, input int on_c, input int off_c);
        @(negedge mclk);
        if (ac)
            pd_himp[0] = 1'b1;
        else
            pd_under[0] = 1'b1;
        repeat (on_c) @(negedge mclk);
        pd_himp[0] = 1'b0;
        pd_under[0] = 1'b0;
        repeat (off_c) @(negedge mclk);
    endtask

    task automatic test_done();
        repeat (3) @(negedge mclk);
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        rd_q <= reg_rd;
        det_d <= det_start;
        cls_d <= class_run;
        if (det_start[cp] && !det_d[cp])
            det_n++;
        if (class_run[cp] && !cls_d[cp])
            cls_n++;
    end

    always @(negedge mclk)
        if (rd_q)
            check(name_q.pop_front(), reg_rdata, exp_q.pop_front());

    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        test_done();
    end

    initial
    begin
        int c;
        for (int n = 0; n < 4; n++)
            pd_cls[n] = 3'($random(seed));
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        repeat (10) @(negedge mclk);
        rd(`OFS_OP_MODE, 8'hff, "op mode");
        rd(`OFS_DISC_EN, 8'h0f, "disc en");
        rd(`OFS_DETCLS_EN, 8'hff, "det cls en");
        for (c = 0; c < 300 && class_run[3] !== 1'b1; c++) @(negedge mclk);
        repeat (8) @(negedge mclk);
        check("class run", class_run[3], 1'b1);
        check("short limit", class_short_limit[3], 1'b1);
        for (c = 0; c < 400 && power_on !== 4'hf; c++) @(negedge mclk);
        check("auto power", power_on, 4'hf);
        check("limit ends", class_short_limit[3], 1'b0);
        rd(`OFS_PWR_ST, 8'h0f, "power st");
        rd(`OFS_DET_EV_COR, 8'hff, "events cor");
        rd(`OFS_DET_EV, 8'h00, "events");
        for (int n = 0; n < 4; n++)
            rd(8'(`OFS_PORT_ST0 + n), {1'b0, pd_cls[n], 4'h1}, "st");
        rd(8'h30, 8'h00, "unmapped");
        repeat (3) load(1'b0, 15, 25);
        check("dc kept", power_on[0], 1'b1);
        load(1'b0, 12, 8);
        load(1'b0, 12, 6);
        check("dc off", power_on[0], 1'b0);
        rd(`OFS_FLT_EV_COR, 8'h10, "fault cor");
        rd(`OFS_FLT_EV_COR, 8'h00, "fault clr");
        wait_pw(0, 1'b1, c);
        // Let the switch-on undercurrent settle before the next burst
        repeat (20) @(negedge mclk);
        load(1'b0, 15, 25);
        check("fresh count", power_on[0], 1'b1);
        wr(`OFS_TIMING, 8'h01);
        rd(`OFS_TIMING, 8'h01, "timing");
        @(negedge mclk);
        pd_under[0] = 1'b1;
        wait_pw(0, 1'b0, c);
        check("dc window", c >= 40 && c <= 50, 1'b1);
        rd(`OFS_FLT_EV_COR, 8'h10, "dc fault");
        pd_under[0] = 1'b0;
        wait_pw(0, 1'b1, c);
        wr(`OFS_DISC_EN, 8'h1f);
        repeat (3) @(negedge mclk);
        check("inject on", sine_injection_pin[1:0], 2'b01);
        // One full period is 16 steps of 4 cycles; flat peaks repeat
        c = 0;
        repeat (64)
        begin
            s = sine_code;
            @(negedge mclk);
            c += int'(sine_code !== s);
        end
        check("sine moves", c >= 12 && c <= 16, 1'b1);
        repeat (2) load(1'b1, 30, 4);
        check("ac kept", power_on[0], 1'b1);
        @(negedge mclk);
        pd_himp[0] = 1'b1;
        wait_pw(0, 1'b0, c);
        check("ac window", c >= 40 && c <= 50, 1'b1);
        pd_himp[0] = 1'b0;
        @(negedge mclk);
        check("inject off", sine_injection_pin[0], 1'b0);
        rd(`OFS_FLT_EV, 8'h10, "ac fault");
        wr(`OFS_OP_MODE, 8'h3f);
        repeat (50) @(negedge mclk);
        check("off port", {power_on[3], det_start[3]}, 2'b00);
        rd(8'h0f, 8'h00, "off status");
        rd(`OFS_DETCLS_EN, 8'h77, "off en");
        rd(`OFS_DISC_EN, 8'h17, "off disc");
        @(negedge mclk);
        resetn = 1'b0;
        self_run = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        repeat (10) @(negedge mclk);
        rd(`OFS_OP_MODE, 8'h55, "sw mode");
        rd(`OFS_DETCLS_EN, 8'h00, "sw en");
        det_n = 0;
        cls_n = 0;
        wr(`OFS_DETCLS_EN, 8'h11);
        repeat (200) @(negedge mclk);
        check("one detect", det_n, 1);
        check("one class", cls_n, 1);
        check("no power", power_on, 4'h0);
        rd(`OFS_DET_EV_COR, 8'h11, "manual ev");
        wr(`OFS_PWR_PB, 8'h01);
        repeat (3) @(negedge mclk);
        check("push on", power_on[0], 1'b1);
        wr(`OFS_PWR_PB, 8'h10);
        repeat (3) @(negedge mclk);
        check("push off", power_on[0], 1'b0);
        cp = 1;
        wr(`OFS_OP_MODE, 8'h59);
        det_n = 0;
        wr(`OFS_DETCLS_EN, 8'h22);
        repeat (300) @(negedge mclk);
        check("semi repeats", det_n >= 2, 1'b1);
        check("semi unpowered", power_on[1], 1'b0);
        rd(`OFS_DET_EV, 8'h22, "semi ev");
        rd(8'h0d, {1'b0, pd_cls[1], 4'h1}, "semi st");
        wr(`OFS_OP_MODE, 8'h79);
        wr(`OFS_DISC_EN, 8'h04);
        wr(`OFS_DETCLS_EN, 8'h66);
        wait_pw(2, 1'b1, c);
        check("sw auto", power_on[2:1], 2'b10);
        test_done();
    end
endmodule
